// File: common/sfp_pkg.sv
/*
  shared constants for the serial flash programming port: memory sizes,
  command opcodes, fuse and lock positions, link timing and host register map.
  assumes a 10 MHz ref_clk_i on both ends.
*/
package sfp_pkg;

  // ************************************************************
  // clock and link timing
  // ************************************************************
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned SCK_MAX_HZ   = 5_000_000;
  localparam int unsigned SCK_HALF_NS  = 400;
  // least time, rounded up, never under one cycle
  localparam int unsigned SCK_HALF_RAW = (SCK_HALF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned SCK_HALF_CYC = (SCK_HALF_RAW < 1) ? 1 : SCK_HALF_RAW;
  localparam int unsigned POR_TIME_NS  = 50_000;
  localparam int unsigned POR_CYCLES   = (POR_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int unsigned POR_CNT_W    = 10;
  localparam int unsigned FRAME_BITS   = 32;

  // ************************************************************
  // memory organisation
  // ************************************************************
  localparam int unsigned PAGE_BYTES = 64;
  localparam int unsigned CODE_BYTES = 8192;
  localparam int unsigned DATA_BYTES = 1024;
  localparam int unsigned USIG_BYTES = 128;
  localparam int unsigned MSIG_BYTES = 64;
  localparam int unsigned FUSE_BYTES = 64;
  localparam int unsigned LOCK_BYTES = 64;
  localparam int unsigned ERASE_W    = 13;
  localparam logic [7:0]  ERASED     = 8'hff;
  localparam logic [7:0]  ENABLED    = 8'h00;
  localparam logic [7:0]  MSIG_SEED  = 8'h5a; // arbitrary value
  localparam logic [5:0]  FUSE_PROG_EN_IDX = 6'h00;
  localparam logic [5:0]  FUSE_RST_DIS_IDX = 6'h01;
  localparam logic [5:0]  LOCK_WP_IDX      = 6'h00;

  // ************************************************************
  // command opcodes
  // ************************************************************
  localparam logic [7:0] OP_RD_CODE   = 8'h01;
  localparam logic [7:0] OP_WR_CODE   = 8'h02;
  localparam logic [7:0] OP_RD_DATA   = 8'h03;
  localparam logic [7:0] OP_WR_DATA   = 8'h04;
  localparam logic [7:0] OP_RD_USIG   = 8'h05;
  localparam logic [7:0] OP_WR_USIG   = 8'h06;
  localparam logic [7:0] OP_RD_MSIG   = 8'h07;
  localparam logic [7:0] OP_RD_FUSE   = 8'h08;
  localparam logic [7:0] OP_WR_FUSE   = 8'h09;
  localparam logic [7:0] OP_WR_FUSE_AE = 8'h0a;
  localparam logic [7:0] OP_RD_LOCK   = 8'h0b;
  localparam logic [7:0] OP_WR_LOCK   = 8'h0c;
  localparam logic [7:0] OP_CHIP_ERASE = 8'h0d;
  localparam logic [7:0] OP_RD_STATUS = 8'h0e;

  // ************************************************************
  // host register map (byte offsets, one word each)
  // ************************************************************
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_CMD   = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STAT  = 8'h0c;
  localparam int unsigned CTRL_HOLD_BIT = 0;
  localparam int unsigned CTRL_GO_BIT   = 1;
  localparam int unsigned CMD_OP_LSB    = 0;
  localparam int unsigned CMD_ADDR_LSB  = 8;
  localparam int unsigned STAT_BUSY_BIT = 0;
  localparam int unsigned STAT_RD_LSB   = 8;
  localparam logic        CTRL_HOLD_RST = 1'b1;

endpackage

// File: common/sfp_link_if.sv
/*
  four-wire programming link plus target reset line.
  assumes a pull-up on the slave-out wire while the device does not drive it.
*/
`timescale 1ns/10ps
interface sfp_link_if;
  logic sck;
  logic mosi;
  logic ss_n;
  logic rst_n;
  logic miso_out;
  logic miso_oe;
  logic miso;

  // wire level: pull-up when released
  assign miso = miso_oe ? miso_out : 1'b1;

  modport dev  (input sck, input mosi, input ss_n, input rst_n, output miso_out, output miso_oe);
  modport host (output sck, output mosi, output ss_n, output rst_n, input miso);
endinterface

// File: core/sfp_dev_port.sv
/*
  device end of the serial flash programming port: mode entry, spi slave,
  code/data/signature/fuse/lock memories.
  assumes reset_i is the power-on reset and the link pins are asynchronous.
*/
`timescale 1ns/10ps

// Contract
// - spi mode 0 only, sck at most 5 MHz
// - programmer is master, device is slave
// - programming mode only while reset pin low
// - link driven by sck, not system clock; the device logic samples sck on ref_clk_i instead
// - board leaves spi lines alone during reset
// - disabled reset pin still acts at power-up
// - disabled-reset session ends on pin high
// - entry any reset only with enable fuse
// - slave select held defined during reset
// - all memories use 64-byte pages
// - one command touches one page only
// - each memory has own space and commands
// - 128-byte user and 64-byte maker signature
// - fuse row survives chip erase
// - writing 00h enables, erase restores FFh
// - fuse clear via read-modify-auto-erase write
// - lock bits cleared only by chip erase
// - 8K code and 1K data reachable
module sfp_dev_port
  import sfp_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  sfp_link_if.dev   link,
  output logic      prog_mode_o,
  output logic      erase_busy_o
);

  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic [1:0] {PH_CMD, PH_AHI, PH_ALO, PH_DATA} sfp_phase_t;

  typedef struct packed {
    logic [2:0]           sck_sy;
    logic [1:0]           mosi_sy;
    logic [1:0]           ss_sy;
    logic [1:0]           rst_sy;
    logic [POR_CNT_W-1:0] por_cnt;
    logic                 prog;
    sfp_phase_t           phase;
    logic [2:0]           bit_cnt;
    logic [7:0]           rx;
    logic [7:0]           tx;
    logic [7:0]           cmd;
    logic [15:0]          addr;
    logic                 miso;
    logic                 miso_oe;
    logic                 erasing;
    logic [ERASE_W-1:0]   erase_cnt;
  } sfp_dev_state_t;

  localparam sfp_dev_state_t DEV_RST = '{
    sck_sy: 3'h0, mosi_sy: 2'h0, ss_sy: 2'h3, rst_sy: 2'h3,
    por_cnt: POR_CNT_W'(POR_CYCLES), prog: 1'b0, phase: PH_CMD, bit_cnt: 3'h0,
    rx: 8'h00, tx: 8'h00, cmd: 8'h00, addr: 16'h0000, miso: 1'b1, miso_oe: 1'b0,
    erasing: 1'b0, erase_cnt: '0};

  sfp_dev_state_t s_r;
  sfp_dev_state_t s_nxt;

  // power-up content stands in for an erased part; arrays keep their value over reset
  logic [7:0] code_mem [CODE_BYTES] = '{default: ERASED};
  logic [7:0] data_mem [DATA_BYTES] = '{default: ERASED};
  logic [7:0] usig_mem [USIG_BYTES] = '{default: ERASED};
  logic [7:0] fuse_mem [FUSE_BYTES] = '{default: ERASED};
  logic [7:0] lock_mem [LOCK_BYTES] = '{default: ERASED};

  logic        mem_we;
  logic [15:0] mem_addr;
  logic [7:0]  mem_wdata;

  // ************************************************************
  // helpers
  // ************************************************************
  // address walks inside its page only, wrapping at the boundary
  function automatic logic [15:0] page_next(input logic [15:0] a);
    page_next = {a[15:6], a[5:0] + 6'h01};
  endfunction

  // each opcode reaches at most one array; no shared address space
  function automatic logic [7:0] rd_byte(input logic [7:0] op, input logic [15:0] a, input logic busy);
    unique case (op)
      OP_RD_CODE:   rd_byte = code_mem[a[12:0]];
      OP_RD_DATA:   rd_byte = data_mem[a[9:0]];
      OP_RD_USIG:   rd_byte = usig_mem[a[6:0]];
      OP_RD_MSIG:   rd_byte = {2'h0, a[5:0]} ^ MSIG_SEED; // read-only, arbitrary content
      OP_RD_FUSE:   rd_byte = fuse_mem[a[5:0]];
      OP_RD_LOCK:   rd_byte = lock_mem[a[5:0]];
      OP_RD_STATUS: rd_byte = {7'h00, busy};
      default:      rd_byte = ERASED;
    endcase
  endfunction

  function automatic logic is_write(input logic [7:0] op);
    is_write = (op == OP_WR_CODE) || (op == OP_WR_DATA) || (op == OP_WR_USIG) ||
               (op == OP_WR_FUSE) || (op == OP_WR_FUSE_AE) || (op == OP_WR_LOCK);
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  logic       rise;
  logic       fall;
  logic       rst_low;
  logic       por_act;
  logic       fuse_any;
  logic       locked;
  logic [7:0] rxb;
  logic [7:0] rdv;

  always_comb begin
    s_nxt     = s_r;
    mem_we    = 1'b0;
    mem_addr  = s_r.addr;
    mem_wdata = 8'h00;
    rdv       = ERASED;
    // two flops on every pin before use
    s_nxt.sck_sy  = {s_r.sck_sy[1:0], link.sck};
    s_nxt.mosi_sy = {s_r.mosi_sy[0], link.mosi};
    s_nxt.ss_sy   = {s_r.ss_sy[0], link.ss_n};
    s_nxt.rst_sy  = {s_r.rst_sy[0], link.rst_n};
    rise    = s_r.sck_sy[1] & ~s_r.sck_sy[2];
    fall    = ~s_r.sck_sy[1] & s_r.sck_sy[2];
    rxb     = {s_r.rx[6:0], s_r.mosi_sy[1]};
    rst_low = ~s_r.rst_sy[1];
    por_act = (s_r.por_cnt != '0);
    locked  = (lock_mem[LOCK_WP_IDX] == ENABLED);
    if (por_act) begin
      s_nxt.por_cnt = s_r.por_cnt - POR_CNT_W'(1);
    end
    // late entry needs the enable fuse and a live reset pin
    fuse_any   = (fuse_mem[FUSE_PROG_EN_IDX] == ENABLED) && (fuse_mem[FUSE_RST_DIS_IDX] != ENABLED);
    // disabled pin: only por entry, so a new session needs a power cycle
    s_nxt.prog = rst_low & (s_r.prog | por_act | fuse_any);
    if (s_r.erasing) begin
      s_nxt.erase_cnt = s_r.erase_cnt + ERASE_W'(1);
      if (s_r.erase_cnt == ERASE_W'(CODE_BYTES - 1)) begin
        s_nxt.erasing = 1'b0;
      end
    end
    if (!s_r.prog || s_r.ss_sy[1]) begin
      s_nxt.phase   = PH_CMD;
      s_nxt.bit_cnt = 3'h0;
      s_nxt.miso_oe = 1'b0;
      s_nxt.miso    = 1'b1;
    end else begin
      s_nxt.miso_oe = 1'b1;
      // no shift on the fall that closes the byte just loaded
      if (fall && s_r.bit_cnt != 3'h0) begin
        s_nxt.miso = s_r.tx[7];
        s_nxt.tx   = {s_r.tx[6:0], 1'b0};
      end
      if (rise) begin
        s_nxt.rx      = rxb;
        s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
        if (s_r.bit_cnt == 3'h7) begin
          unique case (s_r.phase)
            PH_CMD: begin
              s_nxt.cmd   = rxb;
              s_nxt.phase = PH_AHI;
            end
            PH_AHI: begin
              s_nxt.addr  = {rxb, s_r.addr[7:0]};
              s_nxt.phase = PH_ALO;
            end
            PH_ALO: begin
              s_nxt.addr  = {s_r.addr[15:8], rxb};
              s_nxt.phase = PH_DATA;
              rdv         = rd_byte(s_r.cmd, {s_r.addr[15:8], rxb}, s_r.erasing);
              if (s_r.cmd == OP_CHIP_ERASE && !s_r.erasing) begin
                s_nxt.erasing   = 1'b1;
                s_nxt.erase_cnt = '0;
              end
            end
            PH_DATA: begin
              // writes during erase or to locked code/data are dropped
              mem_we = is_write(s_r.cmd) && !s_r.erasing &&
                       !(locked && (s_r.cmd == OP_WR_CODE || s_r.cmd == OP_WR_DATA));
              mem_wdata   = rxb;
              s_nxt.addr  = page_next(s_r.addr);
              rdv         = rd_byte(s_r.cmd, page_next(s_r.addr), s_r.erasing);
            end
          endcase
          s_nxt.miso = rdv[7];
          s_nxt.tx   = {rdv[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      s_r <= DEV_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ************************************************************
  // nonvolatile arrays
  // ************************************************************
  // one byte per cycle keeps erase to a single write port per array
  always_ff @(posedge ref_clk_i) begin
    if (s_r.erasing) begin
      code_mem[s_r.erase_cnt] <= ERASED;
      if (s_r.erase_cnt < ERASE_W'(DATA_BYTES)) begin
        data_mem[s_r.erase_cnt[9:0]] <= ERASED;
      end
      if (s_r.erase_cnt < ERASE_W'(LOCK_BYTES)) begin
        lock_mem[s_r.erase_cnt[5:0]] <= ERASED; // fuses and user row untouched
      end
    end
    if (mem_we) begin
      // flash only clears bits; auto-erase fuse write stores outright
      unique case (s_r.cmd)
        OP_WR_CODE:    code_mem[mem_addr[12:0]] <= code_mem[mem_addr[12:0]] & mem_wdata;
        OP_WR_DATA:    data_mem[mem_addr[9:0]]  <= data_mem[mem_addr[9:0]] & mem_wdata;
        OP_WR_USIG:    usig_mem[mem_addr[6:0]]  <= usig_mem[mem_addr[6:0]] & mem_wdata;
        OP_WR_FUSE:    fuse_mem[mem_addr[5:0]]  <= fuse_mem[mem_addr[5:0]] & mem_wdata;
        OP_WR_FUSE_AE: fuse_mem[mem_addr[5:0]]  <= mem_wdata;
        OP_WR_LOCK:    lock_mem[mem_addr[5:0]]  <= lock_mem[mem_addr[5:0]] & mem_wdata;
        default:       ;
      endcase
    end
  end

  assign link.miso_out = s_r.miso;
  assign link.miso_oe  = s_r.miso_oe;
  assign prog_mode_o   = s_r.prog;
  assign erase_busy_o  = s_r.erasing;

endmodule // sfp_dev_port

// File: core/sfp_host_port.sv
/*
  programmer end: ahb-lite register slave, spi mode 0 master, target reset.
  assumes one ahb master, word accesses, and a device end on the link.
*/
`timescale 1ns/10ps
module sfp_host_port
  import sfp_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        reset_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  sfp_link_if.host         link
);

  // ************************************************************
  // state
  // ************************************************************
  typedef enum logic [2:0] {H_IDLE, H_SETUP, H_HIGH, H_LOW, H_END} sfp_hst_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hready;
    logic        wr_pend;
    logic [7:0]  wr_addr;
    logic        hold;
    logic [7:0]  op;
    logic [15:0] addr;
    logic [7:0]  wdata;
    sfp_hst_t    st;
    logic [2:0]  div;
    logic [4:0]  bit_cnt;
    logic [31:0] frame;
    logic [7:0]  rx;
    logic [7:0]  rdata;
    logic [1:0]  miso_sy;
    logic        sck;
    logic        mosi;
    logic        ss_n;
  } sfp_host_state_t;

  localparam sfp_host_state_t HOST_RST = '{
    hrdata: 32'h0000_0000, hready: 1'b1, wr_pend: 1'b0, wr_addr: 8'h00, hold: CTRL_HOLD_RST,
    op: 8'h00, addr: 16'h0000, wdata: 8'h00, st: H_IDLE, div: 3'h0, bit_cnt: 5'h00,
    frame: 32'h0000_0000, rx: 8'h00, rdata: 8'h00, miso_sy: 2'h3, sck: 1'b0, mosi: 1'b0,
    ss_n: 1'b1};

  sfp_host_state_t s_r;
  sfp_host_state_t s_nxt;
  logic            half_done;
  logic            busy;

  always_comb begin
    s_nxt         = s_r;
    s_nxt.miso_sy = {s_r.miso_sy[0], link.miso};
    busy          = (s_r.st != H_IDLE);
    half_done     = (s_r.div == 3'(SCK_HALF_CYC - 1));
    s_nxt.div     = half_done ? 3'h0 : s_r.div + 3'h1;
    // ************************************************************
    // ahb-lite slave, zero wait states, always okay
    // ************************************************************
    s_nxt.wr_pend = 1'b0;
    if (hsel_i && hready_i && htrans_i[1]) begin
      s_nxt.wr_pend = hwrite_i;
      s_nxt.wr_addr = haddr_i[7:0];
      unique case (haddr_i[7:0])
        REG_CTRL:  s_nxt.hrdata = {31'h0, s_r.hold};
        REG_CMD:   s_nxt.hrdata = {8'h00, s_r.addr, s_r.op};
        REG_WDATA: s_nxt.hrdata = {24'h0, s_r.wdata};
        REG_STAT:  s_nxt.hrdata = {16'h0, s_r.rdata, 7'h00, busy};
        default:   s_nxt.hrdata = 32'h0000_0000;
      endcase
    end
    // ************************************************************
    // spi master, mode 0, msb first
    // ************************************************************
    unique case (s_r.st)
      H_IDLE: begin
        s_nxt.div = 3'h0;
        if (s_r.wr_pend && s_r.wr_addr == REG_CTRL && hwdata_i[CTRL_GO_BIT]) begin
          s_nxt.frame   = {s_r.op, s_r.addr, s_r.wdata};
          s_nxt.mosi    = s_r.op[7];
          s_nxt.ss_n    = 1'b0;
          s_nxt.bit_cnt = 5'h00;
          s_nxt.st      = H_SETUP;
        end
      end
      H_SETUP, H_LOW: begin
        if (half_done) begin
          s_nxt.sck = 1'b1;
          s_nxt.st  = H_HIGH;
        end
      end
      H_HIGH: begin
        if (half_done) begin
          // sample late in the high phase: device updates after the fall
          s_nxt.rx      = {s_r.rx[6:0], s_r.miso_sy[1]};
          s_nxt.sck     = 1'b0;
          s_nxt.bit_cnt = s_r.bit_cnt + 5'h01;
          s_nxt.frame   = {s_r.frame[30:0], 1'b0};
          s_nxt.mosi    = s_r.frame[30];
          s_nxt.st      = (s_r.bit_cnt == 5'(FRAME_BITS - 1)) ? H_END : H_LOW;
        end
      end
      H_END: begin
        if (half_done) begin
          s_nxt.ss_n  = 1'b1;
          s_nxt.rdata = s_r.rx;
          s_nxt.st    = H_IDLE;
        end
      end
      default: s_nxt.st = H_IDLE;
    endcase
    // register writes land in the data phase
    if (s_r.wr_pend) begin
      unique case (s_r.wr_addr)
        REG_CTRL:  s_nxt.hold = hwdata_i[CTRL_HOLD_BIT];
        REG_CMD: begin
          if (!busy) begin
            s_nxt.op   = hwdata_i[CMD_OP_LSB +: 8];
            s_nxt.addr = hwdata_i[CMD_ADDR_LSB +: 16];
          end
        end
        REG_WDATA: s_nxt.wdata = busy ? s_r.wdata : hwdata_i[7:0];
        default:   ;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      s_r <= HOST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // target held in reset from our own reset onward ss_n never floats
  assign link.sck    = s_r.sck;
  assign link.mosi   = s_r.mosi;
  assign link.ss_n   = s_r.ss_n;
  assign link.rst_n  = ~s_r.hold;
  assign hreadyout_o = s_r.hready;
  assign hresp_o     = 1'b0 & s_r.hready;
  assign hrdata_o    = s_r.hrdata;

endmodule // sfp_host_port

// File: tb/sfp_link_asserts.sv
/*
  link checker: frame shape, clock phases and mode exit seen on the link.
  assumes one 10 MHz domain and the link wires of one host and one device.
*/
`timescale 1ns/10ps
module sfp_link_asserts (
  input  wire logic ref_clk_i,
  input  wire logic reset_i,
  input  wire logic sck,
  input  wire logic mosi,
  input  wire logic ss_n,
  input  wire logic rst_n,
  input  wire logic miso_oe,
  input  wire logic prog_mode_i
);
  // ************************************************************
  // rising sck edges within one select
  // ************************************************************
  logic       sck_d_r;
  logic [5:0] rise_cnt_r;
  logic [5:0] rise_cnt_nxt;

  always_comb begin
    rise_cnt_nxt = ss_n ? 6'h00 : rise_cnt_r + {5'h00, sck & ~sck_d_r};
  end

  always_ff @(posedge ref_clk_i) begin
    sck_d_r    <= reset_i ? 1'b0 : sck;
    rise_cnt_r <= reset_i ? 6'h00 : rise_cnt_nxt;
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);

  // ************************************************************
  // assertions
  // ************************************************************
  rst_values_a: assert property ($fell(reset_i) |-> ss_n && !sck && !rst_n && !miso_oe && !prog_mode_i)
    else $error("link not idle after reset");
  sck_idle_a: assert property (ss_n |-> !sck)
    else $error("sck high while deselected");
  mosi_hold_a: assert property (sck && $past(sck) |-> $stable(mosi))
    else $error("mosi moved while sck high");
  sck_high_a: assert property ($rose(sck) |-> sck[*4] ##1 !sck)
    else $error("sck high phase wrong length");
  frame_start_a: assert property ($fell(ss_n) |-> (!sck)[*3] ##[1:3] sck)
    else $error("first sck edge misplaced");
  frame_len_a: assert property ($fell(ss_n) |-> ##[250:280] $rose(ss_n))
    else $error("frame length wrong");
  edge_count_a: assert property ($rose(ss_n) |-> rise_cnt_r == 6'h20)
    else $error("frame not 32 sck edges");
  prog_exit_a: assert property (rst_n[*5] |-> !prog_mode_i)
    else $error("mode held with reset pin high");
  miso_quiet_a: assert property (ss_n[*4] |-> !miso_oe)
    else $error("miso driven while deselected");
endmodule // sfp_link_asserts

// File: tb/serial_isp_flash_programming_port_test.sv
/*
  testbench: ahb-lite master on the host end, device end on the link.
  assumes the package opcodes and host register map.
*/
`timescale 1ns/10ps
module serial_isp_flash_programming_port_test import sfp_pkg::*;;
  logic        ref_clk_i   = 1'b0;
  logic        reset_i     = 1'b1;
  logic        hsel        = 1'b0;
  logic [31:0] haddr       = 32'h0;
  logic [1:0]  htrans      = 2'h0;
  logic        hwrite      = 1'b0;
  logic [31:0] hwdata      = 32'h0;
  logic        hold        = 1'b1;
  logic        hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic        prog_mode;
  logic        erase_busy;
  logic [31:0] rd;
  int          fail_count  = 0;
  int          comparisons = 0;

  always #50 ref_clk_i = ~ref_clk_i;

  sfp_link_if link_bus (); // only the two ends touch the link
  sfp_dev_port sfp_dev_port_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .link(link_bus),
    .prog_mode_o(prog_mode), .erase_busy_o(erase_busy));
  sfp_host_port sfp_host_port_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .link(link_bus));
  sfp_link_asserts sfp_link_asserts_inst (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
    .sck(link_bus.sck), .mosi(link_bus.mosi), .ss_n(link_bus.ss_n), .rst_n(link_bus.rst_n),
    .miso_oe(link_bus.miso_oe), .prog_mode_i(prog_mode));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one single word transfer; entered just after a rising edge
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    do @(posedge ref_clk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge ref_clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task automatic frame(input logic [7:0] op, input logic [15:0] a, input logic [7:0] d);
    ahb(1'b1, REG_CMD, {8'h0, a, op});
    ahb(1'b1, REG_WDATA, {24'h0, d});
    ahb(1'b1, REG_CTRL, {30'h0, 1'b1, hold});
    rd = 32'h1;
    while (rd[STAT_BUSY_BIT] !== 1'b0)
      ahb(1'b0, REG_STAT, 32'h0);
  endtask

  task automatic rd_chk(input logic [7:0] op, input logic [15:0] a, input logic [7:0] e);
    frame(op, a, 8'h00);
    check("read byte", {24'h0, rd[15:8]}, {24'h0, e});
  endtask

  task automatic set_hold(input logic h);
    hold = h;
    ahb(1'b1, REG_CTRL, {31'h0, h});
    repeat (10) @(posedge ref_clk_i);
  endtask

  // reset_i doubles as power-on reset; host hold comes back set
  task automatic power_cycle;
    hold = 1'b1;
    reset_i <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
  endtask

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_spaces;
    logic [7:0]  wo[7] = '{OP_WR_CODE, OP_WR_DATA, OP_WR_USIG, OP_WR_FUSE, OP_WR_LOCK, OP_WR_CODE, OP_WR_DATA};
    logic [7:0]  ro[7] = '{OP_RD_CODE, OP_RD_DATA, OP_RD_USIG, OP_RD_FUSE, OP_RD_LOCK, OP_RD_CODE, OP_RD_DATA};
    logic [15:0] ad[7] = '{16'h0006, 16'h0006, 16'h0006, 16'h0006, 16'h0006, 16'h1fff, 16'h03ff};
    logic [7:0]  va[7] = '{8'h11, 8'h22, 8'h33, 8'h00, 8'h00, 8'h55, 8'h66};
    for (int i = 0; i < 7; i++)
      frame(wo[i], ad[i], va[i]);
    for (int i = 0; i < 7; i++)
      rd_chk(ro[i], ad[i], va[i]);
    frame(OP_WR_USIG, 16'h007f, 8'h44);
    rd_chk(OP_RD_USIG, 16'h007f, 8'h44);
    rd_chk(OP_RD_MSIG, 16'h003f, 8'h3f ^ MSIG_SEED);
  endtask

  task automatic t_fuse;
    frame(OP_WR_FUSE, 16'h0005, ENABLED);
    frame(OP_WR_FUSE, 16'h0005, ERASED);
    rd_chk(OP_RD_FUSE, 16'h0005, ENABLED);
    frame(OP_WR_FUSE_AE, 16'h0005, ERASED);
    rd_chk(OP_RD_FUSE, 16'h0005, ERASED);
  endtask

  task automatic t_erase;
    frame(OP_WR_LOCK, {10'h0, LOCK_WP_IDX}, ENABLED);
    frame(OP_WR_CODE, 16'h0010, 8'h12);
    rd_chk(OP_RD_CODE, 16'h0010, ERASED);
    frame(OP_CHIP_ERASE, 16'h0000, 8'h00);
    check("erase busy", {31'h0, erase_busy}, 32'h1);
    rd_chk(OP_RD_STATUS, 16'h0000, 8'h01);
    for (int i = 0; i < 10000 && erase_busy !== 1'b0; i++)
      @(posedge ref_clk_i);
    check("erase done", {31'h0, erase_busy}, 32'h0);
    frame(OP_WR_CODE, 16'h0010, 8'h12);
    rd_chk(OP_RD_CODE, 16'h0010, 8'h12);
    rd_chk(OP_RD_CODE, 16'h0006, ERASED);
    rd_chk(OP_RD_LOCK, 16'h0006, ERASED);
    rd_chk(OP_RD_FUSE, 16'h0006, ENABLED);
    rd_chk(OP_RD_USIG, 16'h0006, 8'h33);
  endtask

  // re-entry outside power-up hinges on the enable fuse
  task automatic t_entry;
    frame(OP_WR_FUSE, {10'h0, FUSE_PROG_EN_IDX}, ENABLED);
    set_hold(1'b0);
    check("mode after release", {31'h0, prog_mode}, 32'h0);
    rd_chk(OP_RD_CODE, 16'h1fff, 8'hff);
    set_hold(1'b1);
    check("mode with fuse", {31'h0, prog_mode}, 32'h1);
    frame(OP_WR_FUSE_AE, {10'h0, FUSE_PROG_EN_IDX}, ERASED);
    set_hold(1'b0);
    set_hold(1'b1);
    check("mode without fuse", {31'h0, prog_mode}, 32'h0);
  endtask

  // pin used as gpio: only power-up entry, even with the enable fuse set
  task automatic t_rst_dis;
    power_cycle();
    check("mode at power cycle", {31'h0, prog_mode}, 32'h1);
    frame(OP_WR_FUSE, {10'h0, FUSE_PROG_EN_IDX}, ENABLED);
    frame(OP_WR_FUSE, {10'h0, FUSE_RST_DIS_IDX}, ENABLED);
    repeat (POR_CYCLES) @(posedge ref_clk_i);
    set_hold(1'b0);
    check("mode after pin high", {31'h0, prog_mode}, 32'h0);
    set_hold(1'b1);
    check("mode, pin disabled", {31'h0, prog_mode}, 32'h0);
    power_cycle();
    check("mode after new power-up", {31'h0, prog_mode}, 32'h1);
  endtask

  initial begin
    #(40000 * 100);
    fail_count++;
    end_sim();
  end

  initial begin
    power_cycle();
    check("mode at power-up", {31'h0, prog_mode}, 32'h1);
    ahb(1'b0, REG_CTRL, 32'h0);
    check("ctrl reset", rd, 32'h1);
    ahb(1'b0, 8'h10, 32'h0);
    check("unmapped read", rd, 32'h0);
    check("hresp", {31'h0, hresp}, 32'h0);
    t_spaces();
    t_fuse();
    t_erase();
    t_entry();
    t_rst_dis();
    end_sim();
  end
endmodule // serial_isp_flash_programming_port_test
